// ---- rtl/stc_delay_reg.sv ----
`timescale 1ns/10ps
// ==========================================================
// Three BCD digits below one binary nibble, up/down by one
module stc_delay_reg (
   input wire logic clk,
   input wire logic rst_b,
   input wire logic step,
   input wire logic up,
   input wire logic zero,
   input wire logic load,
   input wire logic [15:0] load_val,
   output logic [15:0] value
);
   logic [15:0] val_q;
   logic [15:0] val_d;
   logic carry;
   logic [3:0] dig;

   always_comb begin
      val_d = val_q;
      carry = 1'b1;
      dig = 4'h0;
      for (int i = 0; i < 3; i++) begin
         dig = val_q[4*i +: 4];
         if (carry) begin
            if (up) begin
               carry = (dig == 4'h9);
               val_d[4*i +: 4] = carry ? 4'h0 : dig + 4'h1;
            end else begin
               carry = (dig == 4'h0);
               val_d[4*i +: 4] = carry ? 4'h9 : dig - 4'h1;
            end
         end
      end
      if (carry) begin
         val_d[15:12] = up ? val_q[15:12] + 4'h1 : val_q[15:12] - 4'h1;
      end
   end

   always_ff @(posedge clk) begin
      if (!rst_b || zero) begin
         val_q <= '0;
      end else if (load) begin
         val_q <= load_val;
      end else if (step) begin
         val_q <= val_d;
      end
   end

   assign value = val_q;
endmodule

// ---- rtl/stc_pkg.sv ----
// ==========================================================
// Timing base
package stc_pkg;
   localparam int CLK_PERIOD_NS = 10;
   localparam int SAMPLE_INTERVAL_NS = 20000;
   localparam int NUM_PHASES = 10;
   localparam int INTERVAL_CYC = SAMPLE_INTERVAL_NS / CLK_PERIOD_NS;
   localparam int FAST_DIV = 4;
   localparam int SLOW_DIV = 2;
   localparam int MID_DIV = INTERVAL_CYC / (NUM_PHASES * FAST_DIV * SLOW_DIV);
   localparam int CYC_PER_MS = 1000000 / CLK_PERIOD_NS;
   localparam int STRETCH_MS = 50;
   // ==========================================================
   // Phase decode points
   localparam logic [3:0] PH_ZERO = 4'h0;
   localparam logic [3:0] PH_GATE_LO = 4'h1;
   localparam logic [3:0] PH_GATE_HI = 4'h6;
   localparam logic [3:0] PH_FIVE = 4'h5;
   localparam logic [3:0] PH_WRITE = 4'h8;
   localparam logic [3:0] PH_NINE = 4'h9;
   // ==========================================================
   // Sample code and level thresholds
   localparam int CODE_W = 10;
   localparam int DLY_W = 16;
   localparam logic [9:0] CODE_MAX = 10'h3FF;
   localparam logic [9:0] THR_PRESENT = 10'h010;
   localparam logic [9:0] THR_NOMINAL = 10'h100;
   localparam logic [9:0] THR_LIMIT = 10'h3F8;
   // ==========================================================
   // Register map
   localparam logic [7:0] A_CTRL = 8'h00;
   localparam logic [7:0] A_STATUS = 8'h04;
   localparam logic [7:0] A_DELAY = 8'h08;
   localparam logic [7:0] A_PRESET = 8'h0C;
   localparam int CTRL_RUN_BIT = 0;
   localparam int CTRL_ZERO_BIT = 1;
   localparam logic [1:0] CTRL_RST = 2'h1;
endpackage

// ---- rtl/stc_sample_timing.sv ----
`timescale 1ns/10ps
// ==========================================================
module stc_sample_timing #(
   parameter int unsigned STRETCH_CYC = stc_pkg::STRETCH_MS * stc_pkg::CYC_PER_MS
) (
   input wire logic CLK_SYS,
   input wire logic RST_B,
   input wire logic HSEL,
   input wire logic [31:0] HADDR,
   input wire logic [1:0] HTRANS,
   input wire logic HWRITE,
   input wire logic [2:0] HSIZE,
   input wire logic [31:0] HWDATA,
   input wire logic HREADY,
   output logic [31:0] HRDATA,
   output logic HREADYOUT,
   output logic HRESP,
   input wire logic COMP_IN,
   input wire logic HALVE_SET_SW,
   input wire logic HALVE_CLR_SW,
   input wire logic FREEZE_SET_SW,
   input wire logic FREEZE_CLR_SW,
   input wire logic RATE_THRESH,
   input wire logic CTRL_POSITIVE,
   input wire logic REMOTE_PRESET,
   input wire logic [15:0] DSEL_I,
   output logic [15:0] DSEL_O,
   output logic DSEL_OE,
   output logic [9:0] MEM_DATA_O,
   output logic MEM_DATA_OE,
   input wire logic [9:0] MEM_RDATA,
   output logic MEM_WE,
   output logic MEM_CE,
   output logic MEM_REFRESH,
   output logic PTR_DEC,
   output logic [3:0] SAMPLE_PHASE,
   output logic [11:0] DAC_WORD,
   output logic PRESENT_LED,
   output logic NOMINAL_LED,
   output logic LIMIT_LED,
   output logic HALVING_IND,
   output logic FREEZE_IND,
   output logic COUNT_UP,
   output logic CAP_DISCHARGE
);
   localparam logic [1:0] FAST_LAST = 2'(stc_pkg::FAST_DIV - 1);
   localparam logic [4:0] MID_LAST = 5'(stc_pkg::MID_DIV - 1);
   localparam int SW = $clog2(STRETCH_CYC + 1);
   localparam logic [SW-1:0] STRETCH_LOAD = SW'(STRETCH_CYC);

   // ==========================================================
   // Input synchronisers
   logic [24:0] sync1_q;
   logic [24:0] sync2_q;
   wire logic [24:0] raw_in = {DSEL_I, REMOTE_PRESET, CTRL_POSITIVE, RATE_THRESH,
      FREEZE_CLR_SW, FREEZE_SET_SW, HALVE_CLR_SW, HALVE_SET_SW, COMP_IN, 1'b0};

   always_ff @(posedge CLK_SYS) begin
      if (!RST_B) begin
         sync1_q <= '0;
         sync2_q <= '0;
      end else begin
         sync1_q <= raw_in;
         sync2_q <= sync1_q;
      end
   end

   wire logic comp_s = sync2_q[1];
   wire logic hset_s = sync2_q[2];
   wire logic hclr_s = sync2_q[3];
   wire logic fset_s = sync2_q[4];
   wire logic fclr_s = sync2_q[5];
   wire logic thr_s = sync2_q[6];
   wire logic pos_s = sync2_q[7];
   wire logic rpre_s = sync2_q[8];
   wire logic [15:0] dsel_s = sync2_q[24:9];

   // ==========================================================
   // Timing chain and phase decode
   logic [1:0] fast_q;
   logic [4:0] mid_q;
   logic slow_q;
   logic [3:0] phase_q;

   wire logic fast_tick = (fast_q == FAST_LAST);
   wire logic mid_tick = fast_tick && (mid_q == MID_LAST);
   wire logic slot_tick = mid_tick && slow_q;
   wire logic [3:0] phase_nxt = (phase_q == stc_pkg::PH_NINE) ? stc_pkg::PH_ZERO : phase_q + 4'h1;
   wire logic enter_zero = slot_tick && (phase_nxt == stc_pkg::PH_ZERO);
   wire logic enter_five = slot_tick && (phase_nxt == stc_pkg::PH_FIVE);
   wire logic enter_nine = slot_tick && (phase_nxt == stc_pkg::PH_NINE);

   always_ff @(posedge CLK_SYS) begin
      if (!RST_B) begin
         fast_q <= '0;
         mid_q <= '0;
         slow_q <= 1'b0;
         phase_q <= stc_pkg::PH_ZERO;
      end else begin
         fast_q <= fast_tick ? 2'h0 : fast_q + 2'h1;
         if (fast_tick) begin
            mid_q <= mid_tick ? 5'h00 : mid_q + 5'h01;
         end
         if (mid_tick) begin
            slow_q <= !slow_q;
         end
         if (slot_tick) begin
            phase_q <= phase_nxt;
         end
      end
   end

   // ==========================================================
   // Conversion counters
   logic [1:0] cfast_q;
   logic [9:0] code_q;
   wire logic gate = comp_s && (phase_q >= stc_pkg::PH_GATE_LO) && (phase_q <= stc_pkg::PH_GATE_HI);
   wire logic code_full = (code_q == stc_pkg::CODE_MAX);

   always_ff @(posedge CLK_SYS) begin
      if (!RST_B || enter_nine) begin
         cfast_q <= '0;
         code_q <= '0;
      end else if (gate) begin
         cfast_q <= cfast_q + 2'h1;
         // Saturate so a long pulse never wraps to a small code
         if (cfast_q == FAST_LAST && !code_full) begin
            code_q <= code_q + 10'h001;
         end
      end
   end

   // ==========================================================
   // Mode latches and memory strobes
   logic halve_q;
   logic freeze_q;
   logic tog_q;
   wire logic in_write = (phase_q == stc_pkg::PH_WRITE);
   wire logic freeze_ctl_n = !freeze_q;
   wire logic we_dec = in_write && slow_q && freeze_ctl_n;
   wire logic ce_dec = in_write && (mid_q != 5'h00);
   wire logic ref_dec = in_write && !slow_q;
   wire logic dec_dec = enter_nine && !(halve_q && tog_q);

   always_ff @(posedge CLK_SYS) begin
      if (!RST_B) begin
         halve_q <= 1'b0;
         freeze_q <= 1'b0;
      end else begin
         // Clear wins when both contacts read closed
         halve_q <= !hclr_s && (halve_q || hset_s);
         freeze_q <= !fclr_s && (freeze_q || fset_s);
      end
   end

   always_ff @(posedge CLK_SYS) begin
      if (!RST_B || !halve_q) begin
         tog_q <= 1'b0;
      end else if (enter_five) begin
         tog_q <= !tog_q;
      end
   end

   always_ff @(posedge CLK_SYS) begin
      if (!RST_B) begin
         MEM_WE <= 1'b0;
         MEM_CE <= 1'b0;
         MEM_REFRESH <= 1'b0;
         PTR_DEC <= 1'b0;
         MEM_DATA_OE <= 1'b0;
         MEM_DATA_O <= '0;
      end else begin
         MEM_WE <= we_dec;
         MEM_CE <= ce_dec;
         MEM_REFRESH <= ref_dec;
         PTR_DEC <= dec_dec;
         MEM_DATA_OE <= in_write;
         MEM_DATA_O <= code_q;
      end
   end

   // ==========================================================
   // Level flags and lamp stretchers
   logic [2:0] flag_q;
   logic [SW-1:0] str_q [3];
   wire logic [2:0] reach = {code_q >= stc_pkg::THR_LIMIT, code_q >= stc_pkg::THR_NOMINAL,
      code_q >= stc_pkg::THR_PRESENT};

   always_ff @(posedge CLK_SYS) begin
      if (!RST_B || enter_zero) begin
         flag_q <= '0;
      end else begin
         flag_q <= flag_q | reach;
      end
   end

   // Counter loads on the phase-nine entry, the sampled form of the inverted phase
   always_ff @(posedge CLK_SYS) begin
      for (int i = 0; i < 3; i++) begin
         if (!RST_B) begin
            str_q[i] <= '0;
         end else if (enter_nine && !flag_q[i]) begin
            str_q[i] <= STRETCH_LOAD;
         end else if (str_q[i] != '0) begin
            str_q[i] <= str_q[i] - SW'(1);
         end
      end
   end

   // ==========================================================
   // Rate synchroniser, clocked on the sampling edge
   logic first_q;
   logic second_q;
   wire logic samp_clk = enter_nine;
   wire logic rate_pulse = samp_clk && first_q && !second_q;

   always_ff @(posedge CLK_SYS) begin
      if (!RST_B) begin
         first_q <= 1'b0;
         second_q <= 1'b0;
      end else if (samp_clk) begin
         first_q <= thr_s && !rate_pulse;
         second_q <= rate_pulse;
      end
   end

   // ==========================================================
   // Register bus slave
   logic wr_q;
   logic [7:0] wa_q;
   logic [31:0] rdata_q;
   logic [1:0] ctrl_q;
   logic [15:0] dly_val;
   wire logic ahb_take = HSEL && HTRANS[1] && HREADY;
   wire logic sw_load = wr_q && (wa_q == stc_pkg::A_PRESET);
   wire logic [31:0] status_w = {6'h00, code_q, 4'h0, phase_q, 1'b0, COUNT_UP, tog_q,
      halve_q, freeze_q, flag_q};
   wire logic [31:0] rd_mux = (HADDR[7:0] == stc_pkg::A_CTRL) ? {30'h0000_0000, ctrl_q} :
      (HADDR[7:0] == stc_pkg::A_STATUS) ? status_w :
      (HADDR[7:0] == stc_pkg::A_DELAY) ? {16'h0000, dly_val} : 32'h0000_0000;

   always_ff @(posedge CLK_SYS) begin
      if (!RST_B) begin
         wr_q <= 1'b0;
         wa_q <= '0;
         rdata_q <= '0;
      end else begin
         wr_q <= ahb_take && HWRITE;
         wa_q <= HADDR[7:0];
         if (ahb_take && !HWRITE) begin
            rdata_q <= rd_mux;
         end
      end
   end

   always_ff @(posedge CLK_SYS) begin
      if (!RST_B) begin
         ctrl_q <= stc_pkg::CTRL_RST;
      end else if (wr_q && wa_q == stc_pkg::A_CTRL) begin
         ctrl_q <= HWDATA[1:0];
      end
   end

   assign HRDATA = rdata_q;
   assign HREADYOUT = 1'b1;
   assign HRESP = 1'b0;

   // ==========================================================
   // Delay register, bus drivers and read latches
   logic bus_en_q;
   logic [5:0] lat_lo_q;
   logic [5:0] lat_hi_q;
   wire logic bus_slot = (phase_q == stc_pkg::PH_NINE) && !slow_q;
   wire logic lat_strobe = bus_slot && mid_tick;
   // Remote preset is only honoured while this end is off the bus
   wire logic bus_load = sw_load || (rpre_s && !bus_en_q);
   wire logic [15:0] load_src = sw_load ? HWDATA[15:0] : dsel_s;

   stc_delay_reg u_dly (
      .clk(CLK_SYS),
      .rst_b(RST_B),
      .step(rate_pulse && ctrl_q[stc_pkg::CTRL_RUN_BIT]),
      .up(pos_s),
      .zero(ctrl_q[stc_pkg::CTRL_ZERO_BIT]),
      .load(bus_load),
      .load_val(load_src),
      .value(dly_val)
   );

   always_ff @(posedge CLK_SYS) begin
      if (!RST_B) begin
         bus_en_q <= 1'b0;
         DSEL_O <= '0;
         lat_lo_q <= '0;
         lat_hi_q <= '0;
      end else begin
         bus_en_q <= bus_slot;
         DSEL_O <= dly_val;
         if (lat_strobe) begin
            lat_lo_q <= MEM_RDATA[5:0];
            lat_hi_q <= {2'h0, MEM_RDATA[9:6]};
         end
      end
   end

   assign DSEL_OE = bus_en_q;
   assign DAC_WORD = {lat_hi_q, lat_lo_q};
   assign SAMPLE_PHASE = phase_q;
   assign PRESENT_LED = (str_q[0] != '0);
   assign NOMINAL_LED = (str_q[1] != '0);
   assign LIMIT_LED = (str_q[2] != '0);
   assign HALVING_IND = halve_q;
   assign FREEZE_IND = freeze_q;
   assign COUNT_UP = pos_s;
   assign CAP_DISCHARGE = second_q;

   // ==========================================================
   // Assertions
   default clocking cb @(posedge CLK_SYS); endclocking
   default disable iff (!RST_B);

   a_write_freeze_block: assert property (MEM_WE |-> $past(freeze_ctl_n))
      else $error("write strobe while frozen");
   a_code_clear_after: assert property (enter_nine |=> code_q == 10'h000)
      else $error("code not cleared");
   a_phase_wraps_zero: assert property (enter_zero |=> phase_q == stc_pkg::PH_ZERO)
      else $error("phase did not wrap");
   a_phase_hold_span: assert property ($changed(phase_q) |=> $stable(phase_q) [*8])
      else $error("phase step too short");
   a_dec_skip_halve: assert property (PTR_DEC |-> !$past(halve_q) || !$past(tog_q))
      else $error("decrement not suppressed");
   a_tog_held_clear: assert property (!halve_q |=> !tog_q)
      else $error("toggle set while mode off");
   a_code_gated_only: assert property ((code_q > $past(code_q)) |-> $past(gate))
      else $error("code counted without gate");
   a_rate_phase_nine: assert property (rate_pulse |=> phase_q == stc_pkg::PH_NINE)
      else $error("rate pulse misaligned");
   a_bus_oe_exclusive: assert property (DSEL_OE |-> !MEM_DATA_OE && !MEM_WE)
      else $error("bus driven at write time");
   a_flag_interval: assert property (enter_zero |=> flag_q == 3'h0 ##1 $stable(flag_q))
      else $error("flags not cleared");

   c_halved_skip: cover property (enter_nine && halve_q && tog_q);
   c_rate_fire: cover property (rate_pulse ##1 CAP_DISCHARGE);
   c_lamp_on: cover property ($rose(PRESENT_LED));
   c_sw_preset: cover property (sw_load);
endmodule

// ---- verification/stc_mem_model.sv ----
`timescale 1ns/10ps
// ==========================================================
// Memory board: pointer, delay adder, one small bank
module stc_mem_model (
   input wire logic clk,
   input wire logic dec,
   input wire logic we,
   input wire logic [9:0] wdata,
   input wire logic wdata_oe,
   input wire logic [15:0] dsel,
   input wire logic dsel_oe,
   output logic [9:0] rdata
);
   logic [15:0] ptr_q;
   logic [9:0] last_q;
   logic [9:0] mem [0:63];
   wire logic [5:0] rd_addr = ptr_q[5:0] + dsel[5:0];
   initial begin
      ptr_q = 16'h0000;
      last_q = 10'h000;
      for (int i = 0; i < 64; i++) begin
         mem[i] = 10'(i * 7 + 3);
      end
   end
   // Released read bus flips every cycle so a stale word never passes
   assign rdata = dsel_oe ? mem[rd_addr] : ~last_q;
   always @(posedge clk) begin
      if (dec) begin
         ptr_q <= ptr_q - 16'h0001;
      end
      if (we && wdata_oe) begin
         mem[ptr_q[5:0]] <= wdata;
      end
      last_q <= rdata;
   end
endmodule

// ---- verification/tb.sv ----
`timescale 1ns/10ps
module tb;
   typedef struct packed {logic wr; logic [7:0] addr; logic [31:0] data;} stc_row_t;
   logic clk_sys = 1'b0;
   logic rst_b = 1'b0;
   logic hsel = 1'b0;
   logic hwrite = 1'b0;
   logic [1:0] htrans = 2'h0;
   logic [31:0] haddr = 32'h0000_0000;
   logic [31:0] hwdata = 32'h0000_0000;
   logic comp_in = 1'b1;
   logic [3:0] sw = 4'h0;
   logic rate_thresh = 1'b0;
   logic ctrl_pos = 1'b0;
   logic remote_preset = 1'b0;
   logic [15:0] dsel_drv = 16'h0000;
   logic [31:0] hrdata;
   logic [31:0] rd;
   logic hreadyout, hresp, dsel_oe, mem_data_oe, mem_we, mem_ce, mem_refresh, ptr_dec;
   logic present_led, nominal_led, limit_led, halving_ind, freeze_ind, count_up, cap_discharge;
   logic [15:0] dsel_o, dsel_i, seen_dsel;
   logic [9:0] mem_data_o, mem_rdata, seen_rd;
   logic [2:0] seen_led;
   logic [3:0] sample_phase;
   logic [11:0] dac_word;
   int bad_count = 0;
   int total_checks = 0;
   int cnt [4];
   int n;
   localparam int SLOT = stc_pkg::INTERVAL_CYC / stc_pkg::NUM_PHASES;
   localparam int CODE_FULL = 6 * SLOT / stc_pkg::FAST_DIV;
   localparam stc_row_t ROWS [11] = '{
      '{1'b0, 8'h00, 32'h0000_0001}, '{1'b1, 8'h0C, 32'h0000_0123}, '{1'b0, 8'h08, 32'h0000_0123},
      '{1'b1, 8'h00, 32'h0000_0003}, '{1'b0, 8'h08, 32'h0000_0000}, '{1'b1, 8'h00, 32'h0000_0001},
      '{1'b1, 8'h0C, 32'h0000_0199}, '{1'b0, 8'h08, 32'h0000_0199}, '{1'b0, 8'h10, 32'h0000_0000},
      '{1'b1, 8'h10, 32'h0000_5555}, '{1'b0, 8'h00, 32'h0000_0001}};

   always #5 clk_sys = ~clk_sys;
   // Undriven delay-select lines sit low through the bus resistor network
   assign dsel_i = dsel_oe ? dsel_o : dsel_drv;

   stc_sample_timing #(.STRETCH_CYC(20)) stc_sample_timing_inst (
      .CLK_SYS(clk_sys), .RST_B(rst_b), .HSEL(hsel), .HADDR(haddr), .HTRANS(htrans), .HWRITE(hwrite),
      .HSIZE(3'h2), .HWDATA(hwdata), .HREADY(hreadyout), .HRDATA(hrdata), .HREADYOUT(hreadyout),
      .HRESP(hresp), .COMP_IN(comp_in), .HALVE_SET_SW(sw[0]), .HALVE_CLR_SW(sw[1]),
      .FREEZE_SET_SW(sw[2]), .FREEZE_CLR_SW(sw[3]), .RATE_THRESH(rate_thresh), .CTRL_POSITIVE(ctrl_pos),
      .REMOTE_PRESET(remote_preset), .DSEL_I(dsel_i), .DSEL_O(dsel_o), .DSEL_OE(dsel_oe),
      .MEM_DATA_O(mem_data_o), .MEM_DATA_OE(mem_data_oe), .MEM_RDATA(mem_rdata), .MEM_WE(mem_we),
      .MEM_CE(mem_ce), .MEM_REFRESH(mem_refresh), .PTR_DEC(ptr_dec), .SAMPLE_PHASE(sample_phase),
      .DAC_WORD(dac_word), .PRESENT_LED(present_led), .NOMINAL_LED(nominal_led), .LIMIT_LED(limit_led),
      .HALVING_IND(halving_ind), .FREEZE_IND(freeze_ind), .COUNT_UP(count_up), .CAP_DISCHARGE(cap_discharge));

   stc_mem_model stc_mem_model_inst (
      .clk(clk_sys), .dec(ptr_dec), .we(mem_we), .wdata(mem_data_o), .wdata_oe(mem_data_oe),
      .dsel(dsel_i), .dsel_oe(dsel_oe), .rdata(mem_rdata));

   // ==========================================================
   // Reporting
   task test_done;
      $display("checks %0d mismatches %0d", total_checks, bad_count);
      if (bad_count == 0 && total_checks > 0) begin
         $display("TEST PASSED");
      end else begin
         $display("TEST FAILED");
      end
      $finish;
   endtask

   task chk(input string name, input logic [31:0] seen, input logic [31:0] exp);
      total_checks++;
      if (seen !== exp) begin
         bad_count++;
         $display("unexpected %s expected %h seen %h", name, exp, seen);
      end
   endtask

   task timeout(input string name);
      chk(name, 32'h0000_0000, 32'h0000_0001);
      test_done;
   endtask

   // ==========================================================
   // Bus and timing helpers
   task ahb(input logic wr, input logic [7:0] addr, input logic [31:0] wd);
      int k;
      k = 0;
      @(posedge clk_sys);
      hsel <= 1'b1;
      htrans <= 2'h2;
      haddr <= 32'(addr);
      hwrite <= wr;
      do begin
         @(posedge clk_sys);
         k++;
      end while (hreadyout !== 1'b1 && k < 20);
      hsel <= 1'b0;
      htrans <= 2'h0;
      hwdata <= wd;
      do begin
         @(posedge clk_sys);
         k++;
      end while (hreadyout !== 1'b1 && k < 40);
      rd = hrdata;
      chk("response", hresp, 1'b0);
      if (k >= 40) begin
         timeout("bus ready");
      end
   endtask

   // Returns at the entry of phase p, never part way through it
   task wait_phase(input logic [3:0] p);
      int k;
      k = 0;
      while (sample_phase === p && k < 400) begin
         @(negedge clk_sys);
         k++;
      end
      while (sample_phase !== p && k < 2400) begin
         @(negedge clk_sys);
         k++;
      end
      if (k >= 2400) begin
         timeout("phase");
      end
   endtask

   task wait_cap(input logic v);
      int k;
      k = 0;
      while (cap_discharge !== v && k < 6000) begin
         @(negedge clk_sys);
         k++;
      end
      if (k >= 6000) begin
         timeout("discharge");
      end
   endtask

   task run_iv(input int iv, input int we, input int dec);
      wait_phase(4'h0);
      cnt = '{default: 0};
      repeat (iv * stc_pkg::INTERVAL_CYC) begin
         @(negedge clk_sys);
         cnt[0] += int'(mem_we === 1'b1);
         cnt[1] += int'(mem_refresh === 1'b1);
         cnt[2] += int'(ptr_dec === 1'b1);
         cnt[3] += int'(sample_phase === 4'h9);
      end
      chk("write cycles", cnt[0], we);
      chk("refresh cycles", cnt[1], iv * SLOT / 2);
      chk("decrements", cnt[2], dec);
      chk("phase nine cycles", cnt[3], iv * SLOT);
   endtask

   task obs_nine(input logic [2:0] leds, input logic [15:0] dly);
      wait_phase(4'h9);
      n = 0;
      seen_led = 3'h0;
      for (int i = 0; i < SLOT - 4; i++) begin
         @(negedge clk_sys);
         if (dsel_oe === 1'b1) begin
            n++;
            seen_dsel = dsel_o;
            seen_rd = mem_rdata;
         end
         seen_led |= {limit_led, nominal_led, present_led};
      end
      chk("bus cycles", n, SLOT / 2);
      chk("bus value", seen_dsel, dly);
      chk("dac word", dac_word, {2'b00, seen_rd});
      chk("level lamps", seen_led, leds);
   endtask

   task pulse_sw(input int b);
      @(posedge clk_sys);
      sw[b] <= 1'b1;
      repeat (4) @(posedge clk_sys);
      sw[b] <= 1'b0;
      repeat (5) @(posedge clk_sys);
   endtask

   // ==========================================================
   // Sequence
   initial begin
      #1000000;
      timeout("run length");
   end

   initial begin
      repeat (6) @(posedge clk_sys);
      chk("reset outputs", {mem_we, mem_ce, mem_refresh, ptr_dec, dsel_oe, mem_data_oe, cap_discharge,
          hresp, sample_phase, dac_word, hreadyout}, 32'h0000_0001);
      rst_b <= 1'b1;
      for (int i = 0; i < 11; i++) begin
         ahb(ROWS[i].wr, ROWS[i].addr, ROWS[i].data);
         if (!ROWS[i].wr) begin
            chk("register", rd, ROWS[i].data);
         end
      end
      wait_phase(4'h8);
      ahb(1'b0, 8'h04, 32'h0000_0000);
      chk("sample code", rd[25:16], CODE_FULL);
      chk("level flags", rd[2:0], 3'b011);
      n = 0;
      while (mem_we !== 1'b1 && n < 300) begin
         @(negedge clk_sys);
         n++;
      end
      // Chip enable drops for four cycles as each half-slot starts
      repeat (4) @(negedge clk_sys);
      chk("write word", {mem_data_oe, mem_ce, mem_refresh, mem_data_o}, {3'b110, 10'(CODE_FULL)});
      obs_nine(3'b100, 16'h0199);
      @(posedge clk_sys);
      comp_in <= 1'b0;
      wait_phase(4'h8);
      ahb(1'b0, 8'h04, 32'h0000_0000);
      chk("cleared code", rd[25:16], 10'h000);
      chk("quiet flags", rd[2:0], 3'b000);
      obs_nine(3'b111, 16'h0199);
      run_iv(2, 2 * SLOT / 2, 2);
      pulse_sw(0);
      chk("halving lamp", {halving_ind, freeze_ind}, 2'b10);
      run_iv(4, 4 * SLOT / 2, 2);
      pulse_sw(1);
      pulse_sw(2);
      chk("freeze lamp", {halving_ind, freeze_ind}, 2'b01);
      run_iv(2, 0, 2);
      pulse_sw(3);
      chk("lamps off", {halving_ind, freeze_ind}, 2'b00);
      // Up step carries through two BCD digits, down step borrows back
      @(posedge clk_sys);
      ctrl_pos <= 1'b1;
      rate_thresh <= 1'b1;
      wait_cap(1'b1);
      chk("pulse phase", sample_phase, 4'h9);
      @(posedge clk_sys);
      rate_thresh <= 1'b0;
      chk("direction up", count_up, 1'b1);
      ahb(1'b0, 8'h08, 32'h0000_0000);
      chk("delay up", rd, 32'h0000_0200);
      wait_cap(1'b0);
      @(posedge clk_sys);
      ctrl_pos <= 1'b0;
      rate_thresh <= 1'b1;
      wait_cap(1'b1);
      @(posedge clk_sys);
      rate_thresh <= 1'b0;
      chk("direction down", count_up, 1'b0);
      ahb(1'b0, 8'h08, 32'h0000_0000);
      chk("delay down", rd, 32'h0000_0199);
      dsel_drv <= 16'h0042;
      remote_preset <= 1'b1;
      wait_phase(4'h2);
      @(posedge clk_sys);
      remote_preset <= 1'b0;
      dsel_drv <= 16'h0000;
      ahb(1'b0, 8'h08, 32'h0000_0000);
      chk("remote preset", rd, 32'h0000_0042);
      test_done;
   end
endmodule
